// *** lsef_params.svh ***
// offsets, field positions and reset values of the lin status and error flag block
`ifndef LSEF_PARAMS_SVH
`define LSEF_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LSEF_ADDR_W 8
`define LSEF_DATA_W 8
`define LSEF_OFS_CTRL 8'h08
`define LSEF_OFS_STAT 8'h09
`define LSEF_OFS_ERR 8'h0a
`define LSEF_OFS_IRQ_ST 8'h10
`define LSEF_OFS_IRQ_MASK 8'h11

// ----------------------------------------------------------------
// controller_control_reg bits
// ----------------------------------------------------------------
`define LSEF_CTRL_STOP 7
`define LSEF_CTRL_DATA_ACKNOWLEDGE_CTL 4
`define LSEF_CTRL_CLRINT 3
`define LSEF_CTRL_CLRERR 2

// ----------------------------------------------------------------
// controller_status_reg bits
// ----------------------------------------------------------------
`define LSEF_ST_DATA_REQUEST_FLAG 4
`define LSEF_ST_INT 3
`define LSEF_ST_ERROR 2
`define LSEF_ST_WAKE 1
`define LSEF_ST_DONE 0

// ----------------------------------------------------------------
// controller_error_reg bits and width
// ----------------------------------------------------------------
`define LSEF_ERR_W 5
`define LSEF_ERR_SYNC 4
`define LSEF_ERR_PAR 3
`define LSEF_ERR_TIMEOUT_ERROR 2
`define LSEF_ERR_CHK 1
`define LSEF_ERR_BIT 0

// ----------------------------------------------------------------
// interrupt status and mask bits
// ----------------------------------------------------------------
`define LSEF_IRQ_W 4
`define LSEF_IRQ_DONE 0
`define LSEF_IRQ_IDRX 1
`define LSEF_IRQ_ERR 2
`define LSEF_IRQ_WAKE 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSEF_RST_STAT 8'h00
`define LSEF_RST_ERR 8'h00
`define LSEF_RST_IRQ 4'h0
`define LSEF_RST_RDATA 8'h00

`endif

// *** lsef_pkg.sv ***
// types shared by the lin status and error flag block
`include "lsef_params.svh"

package lsef_pkg;

  // ----------------------------------------------------------------
  // register bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`LSEF_ADDR_W-1:0] addr;
    logic [`LSEF_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lsef_bus_type;

  // ----------------------------------------------------------------
  // frame engine progress events, same clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic slave_mode;
    logic id_received;
    logic int_event;
    logic tx_start;
    logic tx_done;
    logic wakeup_tx;
    logic wakeup_rx;
    logic break_det;
  } lsef_frame_type;

  // ----------------------------------------------------------------
  // frame engine error detectors, same clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync_tol_fail;
    logic parity_fail;
    logic master_no_resp;
    logic slave_no_data;
    logic frame_too_long;
    logic first_byte_done;
    logic checksum_fail;
    logic tx_active;
    logic bit_sample;
    logic tx_bit;
  } lsef_det_type;

  // ----------------------------------------------------------------
  // controller_error_reg layout, bit 4 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync_field_error;
    logic parity_error;
    logic timeout_error;
    logic checksum_error;
    logic bit_monitor_error;
  } lsef_err_type;

endpackage : lsef_pkg

// *** lsef_sync.sv ***
// three-stage synchroniser for the lin receive pin
`timescale 1ns/1ps

module lsef_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // pin side
  input wire logic i_pin,
  // clock domain side
  output logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // a change counts once stages two and three agree
  always_comb begin
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end

  // idle bus is recessive, so reset to one
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;

endmodule : lsef_sync

// *** lsef_top.sv ***
// lin controller status flags, error causes, control strobes and interrupt
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "lsef_params.svh"

module lsef_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register port
  input wire lsef_pkg::lsef_bus_type i_bus,
  output logic [`LSEF_DATA_W-1:0] o_rdata,
  // frame engine
  input wire lsef_pkg::lsef_frame_type i_frame,
  input wire lsef_pkg::lsef_det_type i_det,
  // lin receive pin
  input wire logic i_lin_rx,
  // controls to frame engine
  output logic o_data_acknowledge_ctl,
  output logic o_stop_req,
  // flags
  output logic [`LSEF_DATA_W-1:0] o_status,
  output lsef_pkg::lsef_err_type o_err,
  // interrupt
  output logic o_irq
);

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  logic rx_lvl;

  lsef_sync lsef_sync_inst (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_lin_rx),
    .o_level(rx_lvl)
  );

  // ----------------------------------------------------------------
  // control writes
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic clr_err;
  logic clr_int;
  logic data_acknowledge_ctl_wr;
  logic stop_wr;
  logic ack_wr;

  always_comb begin
    wr_ctrl = i_bus.wr && (i_bus.addr == `LSEF_OFS_CTRL);
    clr_err = wr_ctrl && i_bus.wdata[`LSEF_CTRL_CLRERR];
    clr_int = wr_ctrl && i_bus.wdata[`LSEF_CTRL_CLRINT];
    data_acknowledge_ctl_wr = wr_ctrl && i_bus.wdata[`LSEF_CTRL_DATA_ACKNOWLEDGE_CTL];
    stop_wr = wr_ctrl && i_bus.wdata[`LSEF_CTRL_STOP];
    ack_wr = data_acknowledge_ctl_wr || stop_wr;
  end

  // ----------------------------------------------------------------
  // error detection
  // ----------------------------------------------------------------
  logic [`LSEF_ERR_W-1:0] err_r;
  logic [`LSEF_ERR_W-1:0] err_nxt;
  logic [`LSEF_ERR_W-1:0] err_set;
  logic awaiting_r;
  logic awaiting_nxt;
  logic ack_miss;
  logic bit_mismatch;
  logic slave;

  always_comb begin
    slave = i_frame.slave_mode;
    // first byte ended with no acknowledge or stop
    ack_miss = slave && i_det.first_byte_done && awaiting_r;
    // compare sampled bus bit with driven bit
    bit_mismatch = i_det.tx_active && i_det.bit_sample && (rx_lvl != i_det.tx_bit);
    err_set = '0;
    err_set[`LSEF_ERR_SYNC] = slave && i_det.sync_tol_fail;
    err_set[`LSEF_ERR_PAR] = slave && i_det.parity_fail;
    err_set[`LSEF_ERR_TIMEOUT_ERROR] = (!slave && i_det.master_no_resp)
                            || (slave && i_det.slave_no_data)
                            || i_det.frame_too_long
                            || ack_miss;
    err_set[`LSEF_ERR_CHK] = i_det.checksum_fail;
    err_set[`LSEF_ERR_BIT] = bit_mismatch;
    // an acknowledge in the same cycle as the byte end is too late
    awaiting_nxt = (slave && i_frame.id_received)
                 || (awaiting_r && !ack_wr && !i_det.first_byte_done);
  end

  // sticky per bit, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `LSEF_ERR_W; gi = gi + 1) begin : g_err
      assign err_nxt[gi] = err_set[gi] || (err_r[gi] && !clr_err);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_r <= `LSEF_ERR_W'(`LSEF_RST_ERR);
      awaiting_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
      awaiting_r <= awaiting_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status flags and control bits
  // ----------------------------------------------------------------
  logic data_request_flag_r;
  logic data_request_flag_nxt;
  logic int_r;
  logic int_nxt;
  logic int_set;
  logic wake_rx_r;
  logic wake_rx_nxt;
  logic done_r;
  logic done_nxt;
  logic data_acknowledge_ctl_r;
  logic data_acknowledge_ctl_nxt;
  logic stop_r;
  logic stop_nxt;

  always_comb begin
    // data request set on identifier, cleared by acknowledge or stop
    data_request_flag_nxt = (slave && i_frame.id_received) || (data_request_flag_r && !ack_wr);
    // pending until cleared, new event wins over clear
    int_set = i_frame.int_event || (slave && i_frame.id_received)
            || i_frame.tx_done || i_frame.wakeup_rx || (|err_set);
    int_nxt = int_set || (int_r && !clr_int);
    // received wakeup held until the next break
    wake_rx_nxt = i_frame.wakeup_rx || (wake_rx_r && !i_frame.break_det);
    // cleared at start, set at finish
    done_nxt = i_frame.tx_done || (done_r && !i_frame.tx_start);
    // self-clears once the frame engine has consumed it
    data_acknowledge_ctl_nxt = data_acknowledge_ctl_wr || (data_acknowledge_ctl_r && !i_det.first_byte_done && !i_frame.tx_done);
    stop_nxt = stop_wr;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_request_flag_r <= 1'b0;
      int_r <= 1'b0;
      wake_rx_r <= 1'b0;
      done_r <= 1'b0;
      data_acknowledge_ctl_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      data_request_flag_r <= data_request_flag_nxt;
      int_r <= int_nxt;
      wake_rx_r <= wake_rx_nxt;
      done_r <= done_nxt;
      data_acknowledge_ctl_r <= data_acknowledge_ctl_nxt;
      stop_r <= stop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  logic [`LSEF_DATA_W-1:0] status;

  always_comb begin
    status = `LSEF_RST_STAT;
    status[`LSEF_ST_DATA_REQUEST_FLAG] = data_request_flag_r;
    status[`LSEF_ST_INT] = int_r;
    status[`LSEF_ST_ERROR] = |err_r;
    // wakeup while sending or after receipt
    status[`LSEF_ST_WAKE] = i_frame.wakeup_tx || wake_rx_r;
    status[`LSEF_ST_DONE] = done_r;
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [`LSEF_IRQ_W-1:0] irq_st_r;
  logic [`LSEF_IRQ_W-1:0] irq_st_nxt;
  logic [`LSEF_IRQ_W-1:0] irq_mask_r;
  logic [`LSEF_IRQ_W-1:0] irq_mask_nxt;
  logic [`LSEF_IRQ_W-1:0] irq_evt;
  logic [`LSEF_IRQ_W-1:0] irq_w1c;

  always_comb begin
    irq_evt = '0;
    irq_evt[`LSEF_IRQ_DONE] = i_frame.tx_done;
    irq_evt[`LSEF_IRQ_IDRX] = slave && i_frame.id_received;
    irq_evt[`LSEF_IRQ_ERR] = |err_set;
    irq_evt[`LSEF_IRQ_WAKE] = i_frame.wakeup_rx;
    irq_w1c = (i_bus.wr && (i_bus.addr == `LSEF_OFS_IRQ_ST))
            ? i_bus.wdata[`LSEF_IRQ_W-1:0] : '0;
    irq_mask_nxt = (i_bus.wr && (i_bus.addr == `LSEF_OFS_IRQ_MASK))
                 ? i_bus.wdata[`LSEF_IRQ_W-1:0] : irq_mask_r;
  end

  // events win over a write-one-to-clear in the same cycle
  generate
    for (gi = 0; gi < `LSEF_IRQ_W; gi = gi + 1) begin : g_irq
      assign irq_st_nxt[gi] = irq_evt[gi] || (irq_st_r[gi] && !irq_w1c[gi]);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_st_r <= `LSEF_RST_IRQ;
      irq_mask_r <= `LSEF_RST_IRQ;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [`LSEF_DATA_W-1:0] rdata_r;
  logic [`LSEF_DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = `LSEF_RST_RDATA;
    if (i_bus.rd) begin
      case (i_bus.addr)
        // clear strobes read back as zero
        `LSEF_OFS_CTRL: rdata_nxt[`LSEF_CTRL_DATA_ACKNOWLEDGE_CTL] = data_acknowledge_ctl_r;
        `LSEF_OFS_STAT: rdata_nxt = status;
        `LSEF_OFS_ERR: rdata_nxt[`LSEF_ERR_W-1:0] = err_r;
        `LSEF_OFS_IRQ_ST: rdata_nxt[`LSEF_IRQ_W-1:0] = irq_st_r;
        `LSEF_OFS_IRQ_MASK: rdata_nxt[`LSEF_IRQ_W-1:0] = irq_mask_r;
        default: rdata_nxt = `LSEF_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= `LSEF_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_r;
  assign o_data_acknowledge_ctl = data_acknowledge_ctl_r;
  assign o_stop_req = stop_r;
  assign o_status = status;
  assign o_err = lsef_pkg::lsef_err_type'(err_r);
  assign o_irq = |(irq_st_r & irq_mask_r);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_data_req_set: assert property (
    (slave && i_frame.id_received) |=> data_request_flag_r)
    else $error("data request flag not set after identifier");

  a_int_hold: assert property (
    (int_r && !clr_int) |=> int_r)
    else $error("interrupt pending dropped without clear");

  a_int_clear: assert property (
    (clr_int && !int_set) |=> !int_r)
    else $error("interrupt pending not cleared");

  a_err_summary: assert property (
    (|err_set) |=> o_status[`LSEF_ST_ERROR])
    else $error("status error flag not raised by an error cause");

  a_err_clear: assert property (
    (clr_err && (err_set == '0)) |=> (err_r == '0) && !o_status[`LSEF_ST_ERROR])
    else $error("errors not cleared by clear errors");

  a_err_sticky: assert property (
    !clr_err |=> ((err_r & $past(err_r)) == $past(err_r)))
    else $error("error flag dropped without clear");

  a_done_cycle: assert property (
    ((i_frame.tx_start && !i_frame.tx_done) |=> !done_r)
      and ((!done_r && !i_frame.tx_done) |=> !done_r))
    else $error("done flag wrong after start");

  a_done_set: assert property (
    i_frame.tx_done |=> done_r)
    else $error("done flag not set at finish");

  a_par_master: assert property (
    (!slave && !err_r[`LSEF_ERR_PAR]) |=> !err_r[`LSEF_ERR_PAR])
    else $error("parity error set outside slave mode");

  a_sync_slave: assert property (
    (slave && i_det.sync_tol_fail) |=> o_err.sync_field_error)
    else $error("sync field error not raised");

  a_bit_mon: assert property (
    (i_det.tx_active && i_det.bit_sample && (rx_lvl != i_det.tx_bit)) |=> o_err.bit_monitor_error)
    else $error("bit monitor error not raised");

  a_ack_timeout: assert property (
    (slave && i_frame.id_received ##1 (!ack_wr && !i_det.first_byte_done)[*1]
      ##1 (slave && i_det.first_byte_done && !ack_wr)) |=> o_err.timeout_error)
    else $error("missing acknowledge did not raise timeout");

  a_timeout_error_frame: assert property (
    i_det.frame_too_long |=> err_r[`LSEF_ERR_TIMEOUT_ERROR])
    else $error("frame length timeout not raised");

  a_chk_set: assert property (
    i_det.checksum_fail |=> o_err.checksum_error)
    else $error("checksum error not raised");

  a_data_acknowledge_ctl_self: assert property (
    (data_acknowledge_ctl_r && !data_acknowledge_ctl_wr && i_det.first_byte_done) |=> !o_data_acknowledge_ctl)
    else $error("data acknowledge not self-cleared");

  a_err_read: assert property (
    (i_bus.rd && (i_bus.addr == `LSEF_OFS_ERR)) |=> (o_rdata[7:5] == 3'h0)
      && (o_rdata[`LSEF_ERR_W-1:0] == $past(err_r)))
    else $error("error register read wrong");

  c_ack_miss: cover property (ack_miss);
  c_clear_race: cover property (clr_err && (|err_set));
  c_tx_frame: cover property (i_frame.tx_start ##[1:50] i_frame.tx_done);
  c_irq: cover property ($rose(o_irq));

endmodule : lsef_top

// *** lsef_lin_node.sv ***
// far-side lin node model: wired-and bus with a pull-up
`timescale 1ns/1ps

module lsef_lin_node (
  // device transmit side
  input wire logic i_tx_active,
  input wire logic i_tx_bit,
  // scenario control: another node pulls the bus dominant
  input wire logic i_force_dom,
  // bus level
  output logic o_bus
);
  // recessive high through the pull-up whenever nobody pulls low
  assign o_bus = (i_tx_active ? i_tx_bit : 1'b1) & ~i_force_dom;
endmodule : lsef_lin_node

// *** lsef_top_test.sv ***
// self-checking testbench of the lin status and error flag block
`timescale 1ns/1ps
`include "lsef_params.svh"

module lsef_top_test;
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [7:0] AC = `LSEF_OFS_CTRL;
  localparam logic [7:0] AS = `LSEF_OFS_STAT;
  localparam logic [7:0] AE = `LSEF_OFS_ERR;
  localparam logic [7:0] AI = `LSEF_OFS_IRQ_ST;
  localparam logic [7:0] AM = `LSEF_OFS_IRQ_MASK;
  localparam logic [7:0] SLV = 8'h80, IDR = 8'h40, INE = 8'h20, TXS = 8'h10;
  localparam logic [7:0] TXD = 8'h08, WTX = 8'h04, WRX = 8'h02, BRK = 8'h01;
  localparam logic [9:0] SYN = 10'h200, PAR = 10'h100, MNR = 10'h080, SND = 10'h040;
  localparam logic [9:0] FTL = 10'h020, FBD = 10'h010, CKF = 10'h008, TXA = 10'h004;
  localparam logic [9:0] BSM = 10'h002, TXB = 10'h001;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  lsef_pkg::lsef_bus_type bus = '0;
  lsef_pkg::lsef_frame_type frame = '0;
  lsef_pkg::lsef_det_type det = '0;
  lsef_pkg::lsef_err_type err;
  logic [7:0] rdata, status, frame_lvl;
  logic [9:0] det_lvl;
  logic lin_rx, data_acknowledge_ctl, stop_req, irq;
  logic force_dom = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  logic [9:0] t_det [10] = '{SYN, SYN, PAR, PAR, MNR, SND, FTL, CKF, MNR, SND};
  logic t_slv [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] t_exp [10] = '{8'h10, 8'h00, 8'h08, 8'h00, 8'h04, 8'h04, 8'h04, 8'h02,
    8'h00, 8'h00};

  always #25 i_clk = ~i_clk;

  lsef_top lsef_top_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(rdata),
    .i_frame(frame), .i_det(det), .i_lin_rx(lin_rx), .o_data_acknowledge_ctl(data_acknowledge_ctl), .o_stop_req(stop_req),
    .o_status(status), .o_err(err), .o_irq(irq));

  lsef_lin_node lsef_lin_node_inst (.i_tx_active(det.tx_active), .i_tx_bit(det.tx_bit),
    .i_force_dom(force_dom), .o_bus(lin_rx));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1;
    chk(rdata, exp, "read data");
  endtask : rdc

  // one-cycle event pulse on top of the level inputs
  task automatic ev(input logic [7:0] f, input logic [9:0] d);
    @(posedge i_clk);
    frame <= f | frame_lvl;
    det <= d | det_lvl;
    @(posedge i_clk);
    frame <= frame_lvl;
    det <= det_lvl;
    #1;
  endtask : ev

  // ----------------------------------------------------------------
  // watchdog: the sequence needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    frame_lvl = 8'h00;
    det_lvl = 10'h000;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rdc(AS, 8'h00);
    rdc(AE, 8'h00);
    chk({7'h0, irq}, 8'h00, "irq after reset");
    ev(TXS, 10'h0);
    chk(status, 8'h00, "done idle");
    ev(TXD, 10'h0);
    chk(status, 8'h09, "done set");
    ev(TXS, 10'h0);
    chk(status, 8'h08, "done cleared at start");
    wr(AC, 8'h08);
    chk(status, 8'h00, "int cleared");
    ev(INE, 10'h0);
    chk(status, 8'h08, "int pending");
    wr(AC, 8'h04);
    chk(status, 8'h08, "int kept on error clear");
    wr(AC, 8'h08);
    rdc(AC, 8'h00);
    // slave data request, acknowledged in time
    frame_lvl = SLV;
    ev(IDR, 10'h0);
    rdc(AS, 8'h18);
    wr(AC, 8'h10);
    chk({7'h0, data_acknowledge_ctl}, 8'h01, "ack set");
    chk(status, 8'h08, "request cleared");
    ev(8'h0, FBD);
    chk({7'h0, data_acknowledge_ctl}, 8'h00, "ack self clear");
    chk({3'h0, err}, 8'h00, "no timeout");
    rdc(AC, 8'h00);
    // no acknowledge before the first byte ends
    ev(IDR, 10'h0);
    ev(8'h0, FBD);
    chk({3'h0, err}, 8'h04, "late ack");
    chk(status, 8'h1c, "error flag");
    wr(AC, 8'h04);
    chk({3'h0, err}, 8'h00, "errors cleared");
    chk(status, 8'h18, "status error cleared");
    rdc(AC, 8'h00);
    wr(AC, 8'h80);
    chk({7'h0, stop_req}, 8'h01, "stop pulse");
    chk(status, 8'h08, "request cleared by stop");
    wr(AC, 8'h08);
    // each detector, in both modes where the mode matters
    for (int i = 0; i < 10; i++) begin
      frame_lvl = t_slv[i] ? SLV : 8'h00;
      ev(8'h0, 10'h0);
      ev(8'h0, t_det[i]);
      chk({3'h0, err}, t_exp[i], "error cause");
      repeat (3) @(posedge i_clk);
      rdc(AE, t_exp[i]);
      chk(status, (t_exp[i] != 8'h00) ? 8'h0c : 8'h00, "status error");
      wr(AC, 8'h0c);
      chk({3'h0, err}, 8'h00, "cleared");
    end
    wr(AE, 8'hff);
    rdc(AE, 8'h00);
    rdc(8'h3f, 8'h00);
    // bit monitor: bus level settles for four cycles before the sample
    det_lvl = TXA;
    ev(8'h0, 10'h0);
    repeat (4) @(posedge i_clk);
    ev(8'h0, BSM);
    chk({3'h0, err}, 8'h00, "bit match");
    det_lvl = TXA | TXB;
    force_dom = 1'b1;
    ev(8'h0, 10'h0);
    repeat (4) @(posedge i_clk);
    ev(8'h0, BSM);
    chk({3'h0, err}, 8'h01, "bit mismatch");
    det_lvl = 10'h0;
    force_dom = 1'b0;
    wr(AC, 8'h0c);
    // wakeup sent, then received
    frame_lvl = WTX;
    ev(8'h0, 10'h0);
    chk(status, 8'h02, "wakeup sending");
    frame_lvl = 8'h00;
    ev(8'h0, 10'h0);
    chk(status, 8'h00, "wakeup idle");
    ev(WRX, 10'h0);
    repeat (3) @(posedge i_clk);
    chk(status, 8'h0a, "wakeup received");
    ev(BRK, 10'h0);
    chk(status, 8'h08, "wakeup gone");
    wr(AC, 8'h08);
    // interrupt: raise, mask, clear
    wr(AI, 8'h0f);
    wr(AM, 8'h04);
    rdc(AM, 8'h04);
    chk({7'h0, irq}, 8'h00, "irq quiet");
    ev(8'h0, CKF);
    chk({7'h0, irq}, 8'h01, "irq raised");
    wr(AM, 8'h00);
    chk({7'h0, irq}, 8'h00, "irq masked");
    rdc(AI, 8'h04);
    wr(AM, 8'h04);
    chk({7'h0, irq}, 8'h01, "irq unmasked");
    wr(AI, 8'h04);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rdc(AI, 8'h00);
    results();
  end
endmodule : lsef_top_test
